// ===== rtl/ctrl_port_if.sv
/*
 * Byte-level control-port link between host and device.
 * Assumes both ends share clk; the serial signalling is abstracted away.
 */
`default_nettype none
interface ctrl_port_if;
   logic       start;     // opens a transaction
   logic       stop;      // stop / spi_frame_latch high
   logic       h_valid;   // host byte valid
   logic [7:0] h_byte;
   logic       d_ready;   // device accepts host byte
   logic       rd_req;    // host asks for a read byte
   logic       d_valid;   // device read byte valid
   logic [7:0] d_byte;
   modport device (input start, stop, h_valid, h_byte, rd_req,
                   output d_ready, d_valid, d_byte);
   modport host (output start, stop, h_valid, h_byte, rd_req,
                 input d_ready, d_valid, d_byte);
endinterface
`default_nettype wire

// ===== rtl/dsp_mem_device.sv
/*
 * Device end: decodes control-port transactions into the coefficient
 * and instruction memories, runs the frame-synchronous staged update
 * and a small frame-stepped core model (slew, delay pool).
 * Assumes frame_start is a one-cycle pulse on clk from frame timing.
 */
`default_nettype none
module dsp_mem_device
   import dsp_mem_pkg::*;
#(
   parameter logic [6:0] CHIP = CHIP_ADDRESS
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   ctrl_port_if.device      port,
   input  wire logic        frame_start,
   input  wire logic [8:0]  core_coef_addr,
   output logic [31:0]      core_coef_data,
   output logic             core_coef_blocked,
   input  wire logic [8:0]  core_instr_addr,
   output logic [39:0]      core_instr_data,
   input  wire logic [8:0]  slew_coef_addr,
   output logic [27:0]      slew_value,
   output logic [15:0]      circular_size,
   output logic             update_busy
);
   typedef enum {IDLE, ADR_HI, ADR_LO, DATA, SKIP} phase_type;
   phase_type   phase, next_phase;
   logic [15:0] addr, next_addr;
   logic [2:0]  count, next_count;
   logic [39:0] shift, next_shift;
   logic        rd, next_rd;
   logic        d_valid, next_d_valid;
   logic [7:0]  d_byte, next_d_byte;
   logic [31:0] coef  [COEF_WORDS];
   logic [39:0] instr [INSTR_WORDS];
   logic        armed, next_armed, busy, next_busy;
   logic [2:0]  upd_idx, next_upd_idx;
   logic [27:0] slew, next_slew;
   logic [15:0] modulo_reg, next_modulo_reg;
   logic        wr_coef, wr_instr;

   // byte count per address region; registers take one byte
   function automatic logic [2:0] width_of(input logic [15:0] a);
      if (a <= COEF_LAST) return 3'(COEF_BYTES);
      if (a >= INSTR_BASE && a <= INSTR_LAST) return 3'(INSTR_BYTES);
      return 3'(REG_BYTES);
   endfunction

   function automatic logic [7:0] read_byte(input logic [15:0] a,
                                             input logic [2:0] i);
      logic [39:0] w;
      w = 40'h0;
      if (a <= COEF_LAST)
         w = {8'h00, 4'h0, coef[a[8:0]][27:0]}; // zero nibble
      else if (a >= INSTR_BASE && a <= INSTR_LAST)
         w = instr[a[8:0]];
      return w[8*i +: 8];
   endfunction

   assign port.d_ready = ce;
   assign port.d_valid = d_valid;
   assign port.d_byte  = d_byte;

   // transaction decoder: chip byte, two address bytes, data
   always_comb begin
      logic [2:0] w;
      w            = width_of(addr);
      next_phase   = phase;
      next_addr    = addr;
      next_count   = count;
      next_shift   = shift;
      next_rd      = rd;
      next_d_valid = 1'b0;
      next_d_byte  = d_byte;
      wr_coef      = 1'b0;
      wr_instr     = 1'b0;
      if (port.start) begin
         next_phase = ADR_HI;
      end else if (port.stop) begin
         next_phase = IDLE; // ends single or burst access
      end else if (port.h_valid) begin
         unique case (phase)
            IDLE:   next_phase = IDLE;
            ADR_HI: begin
               next_rd    = port.h_byte[0];
               next_phase = (port.h_byte[7:1] == CHIP) ? ADR_LO : SKIP;
               next_count = 3'd0;
            end
            ADR_LO: begin
               if (count == 3'd0) begin
                  next_addr[15:8] = port.h_byte;
                  next_count      = 3'd1;
               end else begin
                  next_addr[7:0] = port.h_byte;
                  next_count     = 3'd0;
                  next_phase     = DATA;
               end
            end
            DATA: begin
               next_shift = {shift[31:0], port.h_byte}; // msb first
               next_count = count + 3'd1;
               if (count + 3'd1 == w) begin
                  wr_coef  = !rd && addr <= COEF_LAST;
                  wr_instr = !rd && addr >= INSTR_BASE
                             && addr <= INSTR_LAST;
                  next_count = 3'd0;
                  next_addr  = addr + 16'h0001; // burst step
               end
            end
            SKIP:   next_phase = SKIP;
         endcase
      end else if (port.rd_req && phase == DATA && rd) begin
         next_d_valid = 1'b1;
         next_d_byte  = read_byte(addr, 3'(w - 3'd1 - count));
         next_count   = count + 3'd1;
         if (count + 3'd1 == w) begin
            next_count = 3'd0;
            next_addr  = addr + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         phase  <= IDLE;
         addr   <= 16'h0000;
         count  <= 3'd0;
         shift  <= 40'h0;
         rd     <= 1'b0;
         d_valid <= 1'b0;
         d_byte <= 8'h00;
      end else if (ce) begin
         phase  <= next_phase;
         addr   <= next_addr;
         count  <= next_count;
         shift  <= next_shift;
         rd     <= next_rd;
         d_valid <= next_d_valid;
         d_byte <= next_d_byte;
      end
   end

   // core loses coefficient access during a direct write burst
   assign core_coef_blocked = phase == DATA && !rd && addr <= COEF_LAST;

   // staged update: arm on trigger write, copy at next frame
   always_comb begin
      next_armed   = armed;
      next_busy    = busy;
      next_upd_idx = upd_idx;
      if (busy) begin
         next_upd_idx = upd_idx + 3'd1;
         if (upd_idx + 3'd1 >= coef[COEF_TRIGGER][2:0]
             || upd_idx + 3'd1 == 3'(SLOT_COUNT))
            next_busy = 1'b0;
      end else if (frame_start && armed) begin
         next_busy    = coef[COEF_TRIGGER][2:0] != 3'd0;
         next_armed   = 1'b0;
         next_upd_idx = 3'd0;
      end
      if (wr_coef && addr[8:0] == COEF_TRIGGER)
         next_armed = 1'b1; // set wins over frame clear
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         armed   <= 1'b0;
         busy    <= 1'b0;
         upd_idx <= 3'd0;
      end else if (ce) begin
         armed   <= next_armed;
         busy    <= next_busy;
         upd_idx <= next_upd_idx;
      end
   end
   assign update_busy = busy || armed;

   // memory writes: host port, then staged copy
   // the last byte is still in flight, so the word comes from next_shift;
   // destination is the biased target plus the slot's own address
   always_ff @(posedge clk) begin
      if (ce) begin
         if (wr_coef)
            coef[addr[8:0]] <= {4'h0, next_shift[27:0]}; // 5.23
         else if (busy)
            coef[9'(coef[COEF_TARGET][8:0] + COEF_SLOT_FIRST
                    + 9'(upd_idx))]
               <= coef[COEF_SLOT_FIRST + 9'(upd_idx)];
         if (wr_instr)
            instr[addr[8:0]] <= next_shift;
      end
   end

   // core-side reads; data memory has no host path at all
   always_ff @(posedge clk) begin
      if (rst) begin
         core_coef_data  <= 32'h0;
         core_instr_data <= 40'h0;
         modulo_reg      <= 16'h0000;
      end else if (ce) begin
         core_coef_data  <= core_coef_blocked ? core_coef_data
                                              : coef[core_coef_addr];
         core_instr_data <= instr[core_instr_addr];
         modulo_reg      <= next_modulo_reg;
      end
   end
   assign next_modulo_reg = coef[COEF_MODULO][15:0];
   assign circular_size   = modulo_reg;

   // slew: current value in data memory stepped per frame
   logic [27:0] data_mem [DATA_WORDS]; // delay pool, 512 samples
   always_comb begin
      logic [27:0] tgt;
      tgt = coef[slew_coef_addr][27:0];
      next_slew = slew;
      if (frame_start && slew != tgt)
         next_slew = ($signed(slew) < $signed(tgt)) ? slew + 28'h1
                                                    : slew - 28'h1;
   end
   always_ff @(posedge clk) begin
      if (rst)
         slew <= 28'h0;
      else if (ce)
         slew <= next_slew;
   end
   // data memory holds the value just stepped, not last frame's
   always_ff @(posedge clk) begin
      if (ce && frame_start)
         data_mem[DATA_WORDS - 1] <= next_slew;
   end
   assign slew_value = data_mem[DATA_WORDS - 1];
endmodule
`default_nettype wire

// ===== rtl/dsp_mem_host.sv
/*
 * Host end: turns one user command (address, data word, read
 * or write) into control-port bytes. Assumes one command at a time.
 */
`default_nettype none
module dsp_mem_host
   import dsp_mem_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   ctrl_port_if.host        port,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_read,
   input  wire logic [15:0] cmd_addr,
   input  wire logic [39:0] cmd_word,
   output logic [39:0]      rd_word,
   output logic             rd_done
);
   typedef enum {IDLE, OPEN, HDR, DATA, CLOSE} step_type;
   step_type    step, next_step;
   logic [2:0]  idx, next_idx;
   logic [2:0]  w;
   logic [15:0] a, next_a;
   logic [39:0] word, next_word;
   logic        rd, next_rd;
   logic [39:0] acc, next_acc;
   logic        done, next_done;

   assign w = (a <= COEF_LAST) ? 3'(COEF_BYTES) :
              (a >= INSTR_BASE && a <= INSTR_LAST) ? 3'(INSTR_BYTES) :
              3'(REG_BYTES);
   assign cmd_ready = step == IDLE;

   // byte sequencer: chip byte, address, msb-first data
   always_comb begin
      next_step = step;
      next_idx  = idx;
      next_a    = a;
      next_word = word;
      next_rd   = rd;
      next_acc  = acc;
      next_done = 1'b0;
      port.start   = 1'b0;
      port.stop    = 1'b0;
      port.h_valid = 1'b0;
      port.h_byte  = 8'h00;
      port.rd_req  = 1'b0;
      if (port.d_valid)
         next_acc = {acc[31:0], port.d_byte};
      unique case (step)
         IDLE: if (cmd_valid) begin
            next_a    = cmd_addr;
            next_word = cmd_word;
            next_rd   = cmd_read;
            next_acc  = 40'h0;
            next_step = OPEN;
         end
         OPEN: begin
            port.start = 1'b1;
            next_idx   = 3'd0;
            next_step  = HDR;
         end
         HDR: if (port.d_ready) begin
            port.h_valid = 1'b1;
            port.h_byte  = idx == 3'd0 ? {CHIP_ADDRESS, rd} :
                           idx == 3'd1 ? a[15:8] : a[7:0];
            next_idx     = idx + 3'd1;
            if (idx == 3'd2) begin
               next_idx  = 3'd0;
               next_step = DATA;
            end
         end
         DATA: if (port.d_ready) begin
            if (rd) port.rd_req = 1'b1;
            else begin
               port.h_valid = 1'b1;
               port.h_byte  = word[8*(w - 3'd1 - idx) +: 8];
               if (w == 3'(COEF_BYTES) && idx == 3'd0)
                  port.h_byte[7:4] = 4'h0; // pad above the msb
            end
            next_idx = idx + 3'd1;
            if (idx + 3'd1 == w) next_step = CLOSE;
         end
         CLOSE: begin
            port.stop = 1'b1; // ends the single read or write
            next_done = rd;
            next_step = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         step <= IDLE;
         idx  <= 3'd0;
         a    <= 16'h0000;
         word <= 40'h0;
         rd   <= 1'b0;
         acc  <= 40'h0;
         done <= 1'b0;
      end else if (ce) begin
         step <= next_step;
         idx  <= next_idx;
         a    <= next_a;
         word <= next_word;
         rd   <= next_rd;
         acc  <= next_acc;
         done <= next_done;
      end
   end
   // spacing of staged updates is left to the command source
   assign rd_word = acc;
   assign rd_done = done;
endmodule
`default_nettype wire

// ===== rtl/dsp_mem_pkg.sv
/*
 * Shared constants for the DSP memory control-port access path.
 * Assumes a single 100 MHz clock and byte-wide transfers framed by
 * start/stop strobes from the serial front end (not part of this code).
 */
// Operation
// - coefficient memory, 512 words of 32 bits
// - coefficient is four bytes, top nibble zero
// - coefficients are 5.23 two's-complement fixed point
// - direct coefficient writes block the core
// - data memory unreachable from the control port
// - chip address byte then 16-bit address
// - byte count per location follows from address
// - instruction word is five bytes, unpadded
// - burst continues data without new address
// - address increments after every data word
// - host ends a write with stop/latch
// - location 0 holds circular memory size
// - locations 1 to 5 are staging slots
// - location 6 is target address minus one
// - writing location 7 arms frame update
// - at most five words per frame update
// - update copies once per frame, atomically; dsp_mem_device copies one slot per clock after the frame pulse
// - host waits one frame between updates; dsp_mem_host leaves the spacing to the command source
// - delay pool is 512 samples of data memory
// - slew steps current value toward target each frame
// - instruction memory at 0x0400 to 0x05FF
// - core restarts at each frame; updates apply then
`default_nettype none
package dsp_mem_pkg;
   localparam logic [6:0]  CHIP_ADDRESS     = 7'h34; // arbitrary default
   localparam logic [15:0] COEF_BASE        = 16'h0000;
   localparam logic [15:0] COEF_LAST        = 16'h01FF;
   localparam logic [15:0] INSTR_BASE       = 16'h0400;
   localparam logic [15:0] INSTR_LAST       = 16'h05FF;
   localparam logic [15:0] REG_BASE         = 16'h4000;
   localparam logic [15:0] REG_LAST         = 16'h40FF;
   localparam logic [8:0]  COEF_MODULO      = 9'h000;
   localparam logic [8:0]  COEF_SLOT_FIRST  = 9'h001;
   localparam logic [8:0]  COEF_TARGET      = 9'h006;
   localparam logic [8:0]  COEF_TRIGGER     = 9'h007;
   localparam int          SLOT_COUNT       = 5;
   localparam int          COEF_BYTES       = 4;
   localparam int          INSTR_BYTES      = 5;
   localparam int          REG_BYTES        = 1;
   localparam int          DATA_WORDS       = 512;
   localparam int          COEF_WORDS       = 512;
   localparam int          INSTR_WORDS      = 512;
endpackage
`default_nettype wire

// ===== tb/ctrl_port_monitor.sv
/*
 * Checker for the byte link between host and device ends.
 * Assumes one clock domain, rst synchronous active high.
 */
`default_nettype none
module ctrl_port_monitor
   import dsp_mem_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       start,
   input wire logic       stop,
   input wire logic       h_valid,
   input wire logic [7:0] h_byte,
   input wire logic       d_ready,
   input wire logic       rd_req,
   input wire logic       d_valid,
   input wire logic [7:0] d_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   logic [1:0]  hdr_cnt, next_hdr_cnt;
   logic [7:0]  addr_hi, next_addr_hi;
   logic [15:0] n_data, next_n_data;
   logic [15:0] data_now;
   logic        take, in_data, is_coef, is_instr;

   // reads count requests, since the answer byte lags by a cycle
   assign take     = h_valid && d_ready;
   assign in_data  = hdr_cnt == 2'h3;
   assign is_coef  = addr_hi < 8'h02;
   assign is_instr = addr_hi == 8'h04 || addr_hi == 8'h05;
   assign data_now = n_data + 16'((take && in_data) || rd_req);

   // header position and data count since the last start
   always_comb begin
      next_hdr_cnt = hdr_cnt;
      next_addr_hi = addr_hi;
      next_n_data  = data_now;
      if (take && !in_data) begin
         next_hdr_cnt = hdr_cnt + 2'h1;
         if (hdr_cnt == 2'h1) next_addr_hi = h_byte;
      end
      if (start) begin
         next_hdr_cnt = 2'h0;
         next_n_data  = 16'h0000;
      end
   end

   always_ff @(posedge clk) begin
      hdr_cnt <= rst ? 2'h0 : next_hdr_cnt;
      addr_hi <= rst ? 8'h00 : next_addr_hi;
      n_data  <= rst ? 16'h0000 : next_n_data;
   end

   sequence s_header;
      (h_valid && h_byte[7:1] == CHIP_ADDRESS) ##1 h_valid ##1 h_valid;
   endsequence
   property p_header;
      start |=> s_header;
   endproperty
   property p_no_early_read;
      rd_req |-> in_data || (hdr_cnt == 2'h2 && h_valid);
   endproperty
   property p_read_answer;
      rd_req |=> d_valid;
   endproperty
   property p_valid_cause;
      d_valid |-> $past(rd_req);
   endproperty
   property p_coef_pad_wr;
      (take && in_data && is_coef && n_data[1:0] == 2'h0)
         |-> h_byte[7:4] == 4'h0;
   endproperty
   property p_coef_pad_rd;
      (d_valid && is_coef && n_data[1:0] == 2'h1) |-> d_byte[7:4] == 4'h0;
   endproperty
   property p_coef_count;
      (stop && in_data && is_coef)
         |-> data_now[1:0] == 2'h0 && data_now != 16'h0000;
   endproperty
   property p_instr_count;
      (stop && in_data && is_instr)
         |-> data_now % 5 == 0 && data_now != 16'h0000;
   endproperty

   a_header: assert property (p_header)
      else $error("header bytes missing or wrong chip address");
   a_no_early_read: assert property (p_no_early_read)
      else $error("read request before header done");
   a_read_answer: assert property (p_read_answer)
      else $error("read byte not answered");
   a_valid_cause: assert property (p_valid_cause)
      else $error("read byte without request");
   a_coef_pad_wr: assert property (p_coef_pad_wr)
      else $error("coefficient pad nibble set on write");
   a_coef_pad_rd: assert property (p_coef_pad_rd)
      else $error("coefficient pad nibble set on read");
   a_coef_count: assert property (p_coef_count)
      else $error("coefficient byte count wrong");
   a_instr_count: assert property (p_instr_count)
      else $error("instruction byte count wrong");
endmodule
`default_nettype wire

// ===== tb/dsp_memory_control_access_tb_top.sv
/*
 * Testbench joining host and device ends over the byte link.
 * Assumes the host end frames one location per command.
 */
`default_nettype none
module dsp_memory_control_access_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, frame_start, cmd_valid, cmd_read, cmd_ready;
   logic        rd_done, update_busy, core_coef_blocked;
   logic        saw_blocked = 1'h0;
   logic [27:0] slew_value;
   logic [15:0] cmd_addr, circular_size;
   logic [39:0] cmd_word, rd_word, core_instr_data, w;
   logic [8:0]  core_coef_addr, core_instr_addr, slew_coef_addr;
   logic [31:0] core_coef_data, seed;
   logic [31:0] old_val [5];
   logic [31:0] new_val [5];
   logic [8:0]  caddr [4] = '{9'h000, 9'h008, 9'h010, 9'h1FF};
   logic [39:0] expq [$];
   int          n_fail = 0, n_compared = 0, cycles = 0;

   ctrl_port_if link();
   dsp_mem_host dsp_mem_host_inst (.clk, .rst, .ce(1'h1), .port(link),
      .cmd_valid, .cmd_ready, .cmd_read, .cmd_addr, .cmd_word, .rd_word,
      .rd_done);
   dsp_mem_device dsp_mem_device_inst (.clk, .rst, .ce(1'h1), .port(link),
      .frame_start, .core_coef_addr, .core_coef_data,
      .core_coef_blocked, .core_instr_addr, .core_instr_data,
      .slew_coef_addr, .slew_value, .circular_size, .update_busy);
   ctrl_port_monitor ctrl_port_monitor_inst (.clk, .rst,
      .start(link.start), .stop(link.stop), .h_valid(link.h_valid),
      .h_byte(link.h_byte), .d_ready(link.d_ready), .rd_req(link.rd_req),
      .d_valid(link.d_valid), .d_byte(link.d_byte));

   always #5 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic check(input string what, input logic [39:0] seen,
                        input logic [39:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // one command; the timeout bounds every wait here
   task automatic xfer(input logic rd, input logic [15:0] a,
                       input logic [39:0] wd);
      @(negedge clk);
      cmd_valid = 1'h1;
      cmd_read  = rd;
      cmd_addr  = a;
      cmd_word  = wd;
      // ready is looked at off the edge, so the taking edge is not raced
      while (cmd_ready !== 1'h1) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'h0;
      while (cmd_ready !== 1'h1) @(negedge clk);
   endtask

   task automatic frame_pulse;
      @(negedge clk);
      frame_start = 1'h1;
      @(negedge clk);
      frame_start = 1'h0;
   endtask

   task automatic peek_coef(input logic [8:0] a, input logic [31:0] exp);
      @(negedge clk);
      core_coef_addr = a;
      repeat (2) @(negedge clk);
      check("core_coef_data", 40'(core_coef_data), 40'(exp));
   endtask

   // read results arrive later; pair them with the oldest note
   // a result with no note waiting is a mismatch of its own
   always @(negedge clk)
      if (rd_done === 1'h1) begin
         if (expq.size() == 0) begin
            n_fail++;
            $display("CHECK FAILED rd_word expected none seen %h", rd_word);
         end else
            check("rd_word", rd_word, expq.pop_front());
      end

   // core must lose coefficient access during a direct write
   always @(negedge clk)
      if (core_coef_blocked === 1'h1)
         saw_blocked = 1'h1;

   always @(posedge clk) begin
      cycles++;
      if (cycles >= 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      clk = 1'h0; rst = 1'h1; frame_start = 1'h0; cmd_valid = 1'h0;
      cmd_read = 1'h0; cmd_addr = 16'h0000; cmd_word = 40'h0;
      core_coef_addr = 9'h000; core_instr_addr = 9'h000;
      slew_coef_addr = 9'h000; seed = 32'h4E7D;
      repeat (10) @(negedge clk);
      rst = 1'h0;
      // coefficients: size slot, unity gain, top boundary
      foreach (caddr[i]) begin
         seed = xs(seed);
         w = (i == 2) ? 40'h0000800000 : {8'h00, seed};
         slew_coef_addr = seed[8:0];
         xfer(1'h0, {7'h00, caddr[i]}, w);
         w = {12'h000, w[27:0]}; // pad nibble goes out as zero
         expq.push_back(w);
         xfer(1'h1, {7'h00, caddr[i]}, 40'h0);
         peek_coef(caddr[i], w[31:0]);
         if (i == 0)
            check("circular_size", 40'(circular_size), 40'(w[15:0]));
      end
      // instruction words at both ends of their range
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         w = {seed[7:0], xs(seed)};
         cmd_addr = i ? 16'h05FF : 16'h0400;
         xfer(1'h0, cmd_addr, w);
         expq.push_back(w);
         xfer(1'h1, cmd_addr, 40'h0);
         core_instr_addr = cmd_addr[8:0];
         repeat (2) @(negedge clk);
         check("core_instr_data", core_instr_data, w);
      end
      // register region: one data byte, nothing stored behind it
      xfer(1'h0, 16'h4000, 40'hA5);
      expq.push_back(40'h0);
      xfer(1'h1, 16'h4000, 40'h0);
      slew_coef_addr = 9'h010; // unity target for the slew below
      // full five-word staged update into 0x020..0x024
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         old_val[i] = {4'h0, seed[27:0]};
         new_val[i] = {4'h0, seed[31:4]};
         xfer(1'h0, 16'h0020 + 16'(i), 40'(old_val[i]));
         xfer(1'h0, 16'h0001 + 16'(i), 40'(new_val[i]));
      end
      xfer(1'h0, 16'h0006, 40'h1F);
      xfer(1'h0, 16'h0007, 40'h5); // one request this frame
      check("update_busy", 40'(update_busy), 40'h1);
      peek_coef(9'h020, old_val[0]);
      frame_pulse();
      repeat (8) @(negedge clk);
      check("update_busy", 40'(update_busy), 40'h0);
      check("slew_value", 40'(slew_value), 40'h1);
      for (int i = 0; i < 5; i++)
         peek_coef(9'h020 + 9'(i), new_val[i]);
      repeat (2) frame_pulse();
      check("slew_value", 40'(slew_value), 40'h3);
      check("core_coef_blocked", 40'(saw_blocked), 40'h1);
      repeat (20) @(negedge clk);
      check("pending reads", 40'(expq.size()), 40'h0);
      test_done();
   end
endmodule
`default_nettype wire
